/* File: src/sapf_pkg.sv */
// Package for the successive-approximation converter control block.
// Assumes byte-wide registers on a plain address/strobe port.
package sapf_pkg;
    localparam int unsigned SAPF_ADDR_W = 16;
    localparam logic [15:0] SAPF_OFS_MODE = 16'hff98;
    localparam logic [15:0] SAPF_OFS_CHAN = 16'hff99;
    localparam logic [15:0] SAPF_OFS_PFM = 16'hff9a;
    localparam logic [15:0] SAPF_OFS_THR = 16'hff9b;
    localparam logic [15:0] SAPF_OFS_EMU = 16'hff9c;
    localparam logic [15:0] SAPF_OFS_RESULT = 16'hff9d;
    localparam logic [15:0] SAPF_OFS_FLAG = 16'hff9e;
    localparam logic [7:0] SAPF_RST_BYTE = 8'h00;
    localparam int unsigned SAPF_MODE_EN_BIT = 7;
    localparam int unsigned SAPF_MODE_TSEL_LSB = 3;
    localparam int unsigned SAPF_PFM_EN_BIT = 7;
    localparam int unsigned SAPF_PFM_DIR_BIT = 6;
    localparam int unsigned SAPF_EMU_EN_BIT = 0;
    localparam int unsigned SAPF_FLAG_BIT = 0;
    localparam int unsigned SAPF_NBITS = 8;
    // Conversion time in main clock periods per selection code.
    localparam logic [7:0] SAPF_T_CODE0 = 8'h90;
    localparam logic [7:0] SAPF_T_CODE1 = 8'h78;
    localparam logic [7:0] SAPF_T_CODE2 = 8'h60;
    localparam logic [7:0] SAPF_T_CODE4 = 8'h48;
    localparam logic [7:0] SAPF_T_CODE5 = 8'h3c;
    localparam logic [7:0] SAPF_T_CODE6 = 8'h30;

    typedef enum logic [1:0] {
        SAPF_IDLE = 2'b00,
        SAPF_SAMPLE = 2'b01,
        SAPF_STEP = 2'b10
    } sapf_state_t;

    typedef struct packed {
        logic [2:0] channel;
        logic [7:0] tap;
        logic sample;
    } sapf_afe_t;

    typedef struct packed {
        logic [SAPF_ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sapf_bus_t;
endpackage

/* File: src/sapf_ctrl.sv */
// Control logic for an 8-bit successive-approximation converter with power-fail compare.
// Assumes the analog front end answers the comparator within one step interval.
// Function
// - Power-fail enable selects compare or plain mode
// - Direction bit chooses greater-equal or below interrupt
// - Threshold register read/write, reset to zero
// - Conversion starts with bit 7 mid-scale
// - Keep trial bit when input at/above tap
// - After eight bits copy result, request interrupt
// - Conversions repeat while enable bit stays set
// - Mode or channel write restarts conversion
// - Reset clears result register
// - Plain mode interrupts every conversion, continuous
// - Enable-clear write halts conversion at once
// - Channel rewrite converts new channel
// - Compare mode stores, compares, gated interrupt
// - First conversion after the enable is set gives no compare-mode interrupt
// - Coinciding read returns old result
// - Coinciding mode/channel write suppresses update
// - Channel change leaves interrupt flag alone
// - Result undefined after mode/channel write
// - Three-bit field selects conversion time
// - Compare mode register layout and reset
// - Channel register picks one of eight
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module sapf_ctrl #(
    parameter int unsigned NBITS = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire sapf_pkg::sapf_bus_t bus_i,
    output logic [7:0] rdata_o,
    output sapf_pkg::sapf_afe_t afe_o,
    input wire logic cmp_above_i,
    output logic conversion_end_irq_o,
    output logic conversion_end_flag_o,
    output logic reference_ctrl_enable_o
);
    import sapf_pkg::*;

    logic [7:0] converter_mode_reg_r;
    logic [2:0] channel_select_reg_r;
    logic [1:0] power_fail_mode_reg_r;
    logic [7:0] power_fail_threshold_r;
    logic reference_ctrl_enable_r;
    logic [7:0] conversion_result_r;
    logic [7:0] approximation_reg_r;
    logic [7:0] approximation_reg_nxt;
    logic [7:0] trial_r;
    logic [7:0] rdata_r;
    logic [7:0] step_cnt_r;
    logic [3:0] bit_cnt_r;
    logic first_r;
    logic flag_r;
    logic irq_r;
    logic sample_r;
    sapf_state_t state_r;

    wire wr_mode = bus_i.wr && (bus_i.addr == SAPF_OFS_MODE);
    wire wr_chan = bus_i.wr && (bus_i.addr == SAPF_OFS_CHAN);
    wire wr_pfm = bus_i.wr && (bus_i.addr == SAPF_OFS_PFM);
    wire wr_thr = bus_i.wr && (bus_i.addr == SAPF_OFS_THR);
    wire wr_emu = bus_i.wr && (bus_i.addr == SAPF_OFS_EMU);
    wire wr_flag = bus_i.wr && (bus_i.addr == SAPF_OFS_FLAG);
    wire restart = wr_mode || wr_chan;
    wire conv_en = converter_mode_reg_r[SAPF_MODE_EN_BIT];
    wire pf_en = power_fail_mode_reg_r[1];
    wire pf_dir = power_fail_mode_reg_r[0];
    wire [2:0] tsel = converter_mode_reg_r[SAPF_MODE_TSEL_LSB+2:SAPF_MODE_TSEL_LSB];
    // Only a mode write can change the enable; a channel write keeps the current one.
    wire restart_run = wr_mode ? bus_i.wdata[SAPF_MODE_EN_BIT] : conv_en;

    // Total conversion time; prohibited codes fall back to the slowest setting.
    logic [7:0] conv_clocks;
    always_comb begin
        case (tsel)
            3'h1: conv_clocks = SAPF_T_CODE1;
            3'h2: conv_clocks = SAPF_T_CODE2;
            3'h4: conv_clocks = SAPF_T_CODE4;
            3'h5: conv_clocks = SAPF_T_CODE5;
            3'h6: conv_clocks = SAPF_T_CODE6;
            default: conv_clocks = SAPF_T_CODE0;
        endcase
    end

    // The time is split into NBITS+1 slots: one for sampling, one per bit.
    wire [7:0] slot_len = 8'(conv_clocks / 8'(NBITS + 1));
    wire slot_end = (step_cnt_r == slot_len - 8'h01);

    // Trial bit decision using the comparator answer of this step.
    assign approximation_reg_nxt = cmp_above_i ? approximation_reg_r
                                               : (approximation_reg_r & ~trial_r);
    wire last_bit = (bit_cnt_r == 4'(NBITS - 1));
    wire conv_done = (state_r == SAPF_STEP) && slot_end && last_bit;
    wire ge = approximation_reg_nxt >= power_fail_threshold_r;
    wire hit = pf_dir ? !ge : ge;
    // A coinciding mode/channel write wins: no update and no request.
    wire done_ok = conv_done && !restart;
    wire irq_req = done_ok && (!pf_en || (hit && !first_r));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            converter_mode_reg_r <= SAPF_RST_BYTE;
            channel_select_reg_r <= 3'h0;
            power_fail_mode_reg_r <= 2'h0;
            power_fail_threshold_r <= SAPF_RST_BYTE;
            reference_ctrl_enable_r <= 1'b0;
        end else if (ce_i) begin
            if (wr_mode) begin
                converter_mode_reg_r <= {bus_i.wdata[SAPF_MODE_EN_BIT], 1'b0,
                    bus_i.wdata[SAPF_MODE_TSEL_LSB+2:SAPF_MODE_TSEL_LSB], 3'h0};
            end
            if (wr_chan) begin
                channel_select_reg_r <= bus_i.wdata[2:0];
            end
            if (wr_pfm) begin
                power_fail_mode_reg_r <= {bus_i.wdata[SAPF_PFM_EN_BIT],
                    bus_i.wdata[SAPF_PFM_DIR_BIT]};
            end
            if (wr_thr) begin
                power_fail_threshold_r <= bus_i.wdata;
            end
            if (wr_emu) begin
                reference_ctrl_enable_r <= bus_i.wdata[SAPF_EMU_EN_BIT];
            end
        end
    end

    // Conversion sequencer.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= SAPF_IDLE;
            step_cnt_r <= 8'h00;
            bit_cnt_r <= 4'h0;
            approximation_reg_r <= 8'h00;
            trial_r <= 8'h00;
            sample_r <= 1'b0;
            first_r <= 1'b1;
        end else if (ce_i) begin
            if (restart) begin
                // Abort and start over; a zero enable simply halts.
                state_r <= restart_run ? SAPF_SAMPLE : SAPF_IDLE;
                step_cnt_r <= 8'h00;
                bit_cnt_r <= 4'h0;
                approximation_reg_r <= 8'h00;
                trial_r <= 8'h00;
                sample_r <= restart_run;
                if (wr_mode && !conv_en) begin
                    first_r <= 1'b1;
                end
            end else begin
                case (state_r)
                    SAPF_IDLE: begin
                        sample_r <= 1'b0;
                        first_r <= 1'b1;
                    end
                    SAPF_SAMPLE: begin
                        step_cnt_r <= slot_end ? 8'h00 : step_cnt_r + 8'h01;
                        if (slot_end) begin
                            state_r <= SAPF_STEP;
                            sample_r <= 1'b0;
                            approximation_reg_r <= 8'h80;
                            trial_r <= 8'h80;
                            bit_cnt_r <= 4'h0;
                        end
                    end
                    SAPF_STEP: begin
                        step_cnt_r <= slot_end ? 8'h00 : step_cnt_r + 8'h01;
                        if (slot_end) begin
                            if (last_bit) begin
                                approximation_reg_r <= approximation_reg_nxt;
                                state_r <= SAPF_SAMPLE;
                                sample_r <= 1'b1;
                                first_r <= 1'b0;
                            end else begin
                                approximation_reg_r <= approximation_reg_nxt |
                                                       (trial_r >> 1);
                                trial_r <= trial_r >> 1;
                                bit_cnt_r <= bit_cnt_r + 4'h1;
                            end
                        end
                    end
                    default: state_r <= SAPF_IDLE;
                endcase
            end
        end
    end

    // Result, sticky flag and read data.
    wire rd_hit_result = bus_i.rd && (bus_i.addr == SAPF_OFS_RESULT);
    wire rd_hit_flag = bus_i.rd && (bus_i.addr == SAPF_OFS_FLAG);
    logic [7:0] rd_mux;
    always_comb begin
        case (bus_i.addr)
            SAPF_OFS_MODE: rd_mux = converter_mode_reg_r;
            SAPF_OFS_CHAN: rd_mux = {5'h00, channel_select_reg_r};
            SAPF_OFS_PFM: rd_mux = {power_fail_mode_reg_r, 6'h00};
            SAPF_OFS_THR: rd_mux = power_fail_threshold_r;
            SAPF_OFS_RESULT: rd_mux = conversion_result_r;
            SAPF_OFS_FLAG: rd_mux = {7'h00, flag_r};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conversion_result_r <= SAPF_RST_BYTE;
            flag_r <= 1'b0;
            irq_r <= 1'b0;
            rdata_r <= 8'h00;
        end else if (ce_i) begin
            // The read samples the old value; the new result lands on the same edge.
            rdata_r <= bus_i.rd ? rd_mux : 8'h00;
            if (done_ok) begin
                conversion_result_r <= approximation_reg_nxt;
            end
            irq_r <= irq_req;
            // Set wins over clear; channel writes never touch the flag.
            if (irq_req) begin
                flag_r <= 1'b1;
            end else if (wr_flag && !bus_i.wdata[SAPF_FLAG_BIT]) begin
                flag_r <= 1'b0;
            end
        end
    end

    assign rdata_o = rdata_r;
    assign conversion_end_irq_o = irq_r;
    assign conversion_end_flag_o = flag_r;
    assign reference_ctrl_enable_o = reference_ctrl_enable_r;
    assign afe_o.channel = channel_select_reg_r;
    assign afe_o.tap = approximation_reg_r;
    assign afe_o.sample = sample_r;
endmodule
`default_nettype wire

/* File: verification/sapf_ctrl_properties.sv */
// Port-level checks for the converter control block.
// Assumes one clock and a synchronous reset; the bench lowers ce_i only between pulses.
`timescale 1ns/1ps
`default_nettype none
module sapf_ctrl_properties #(
    parameter int unsigned NBITS = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire sapf_pkg::sapf_bus_t bus_i,
    input wire logic [7:0] rdata_o,
    input wire sapf_pkg::sapf_afe_t afe_o,
    input wire logic cmp_above_i,
    input wire logic conversion_end_irq_o,
    input wire logic conversion_end_flag_o,
    input wire logic reference_ctrl_enable_o
);
    import sapf_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_wr(logic [15:0] a);
        ce_i && bus_i.wr && bus_i.addr == a;
    endsequence
    sequence s_thr_rd;
        ce_i && bus_i.rd && bus_i.addr == SAPF_OFS_THR;
    endsequence
    logic mode_off;
    logic reg_wr;
    assign mode_off = ce_i && bus_i.wr && bus_i.addr == SAPF_OFS_MODE && !bus_i.wdata[7];
    assign reg_wr = ce_i && bus_i.wr &&
        (bus_i.addr == SAPF_OFS_MODE || bus_i.addr == SAPF_OFS_CHAN);
    a_thr_readback: assert property (s_wr(SAPF_OFS_THR) ##1 !bus_i.wr ##1 s_thr_rd |=>
        rdata_o == $past(bus_i.wdata, 3)) else $error("threshold readback differs");
    a_irq_sets_flag: assert property (
        conversion_end_irq_o |-> ##[0:1] conversion_end_flag_o)
        else $error("flag not set by irq");
    a_irq_one_pulse: assert property (conversion_end_irq_o |=> !conversion_end_irq_o)
        else $error("irq longer than one cycle");
    a_halt_no_irq: assert property (
        mode_off |=> (!conversion_end_irq_o && !afe_o.sample) [*8])
        else $error("conversion ran on after halt");
    a_write_no_irq: assert property (reg_wr |=> !conversion_end_irq_o)
        else $error("irq after mode or channel write");
    a_start_samples: assert property (
        s_wr(SAPF_OFS_MODE) ##0 bus_i.wdata[7] |=> afe_o.sample)
        else $error("no sampling after enable");
    a_chan_to_afe: assert property (s_wr(SAPF_OFS_CHAN) |=>
        afe_o.channel == $past(bus_i.wdata[2:0])) else $error("channel not forwarded");
    a_first_tap_mid: assert property ($fell(afe_o.sample) && !$past(bus_i.wr) |->
        afe_o.tap == 8'h80) else $error("first trial is not mid-scale");
endmodule
bind sapf_ctrl sapf_ctrl_properties #(.NBITS(NBITS)) sapf_ctrl_properties_i (.clk_i(clk_i),
    .rst_i(rst_i), .ce_i(ce_i), .bus_i(bus_i), .rdata_o(rdata_o), .afe_o(afe_o),
    .cmp_above_i(cmp_above_i), .conversion_end_irq_o(conversion_end_irq_o),
    .conversion_end_flag_o(conversion_end_flag_o),
    .reference_ctrl_enable_o(reference_ctrl_enable_o));
`default_nettype wire

/* File: verification/sapf_afe_model.sv */
// Behavioural analog front end: sample/hold, tap string and comparator.
// Assumes one input byte per channel, set by the bench.
`timescale 1ns/1ps
`default_nettype none
module sapf_afe_model (
    input wire logic clk_i,
    input wire logic [63:0] vin_i,
    input wire sapf_pkg::sapf_afe_t afe_i,
    output logic cmp_above_o
);
    import sapf_pkg::*;
    logic [7:0] held_r;
    // The hold only tracks the input while sampling, so a late channel change is not seen.
    always_ff @(posedge clk_i) begin
        if (afe_i.sample) begin
            held_r <= vin_i[afe_i.channel*8 +: 8];
        end
    end
    assign cmp_above_o = held_r >= afe_i.tap;
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the converter control block with its analog partner.
// Assumes ce_i high except one freeze; conversion code 6 (45 cycles) outside the timing loop.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sapf_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    sapf_bus_t bus = '0;
    logic [7:0] rdata;
    sapf_afe_t afe;
    logic cmp, irq, flag, refen;
    logic ce = 1'b1;
    logic [63:0] vin = '0;
    logic [7:0] rv;
    int mismatches = 0;
    int n_compared = 0;
    int t, c, v, e;
    int tcode[7] = '{7, 0, 1, 2, 4, 5, 6};
    int tconv[7] = '{144, 144, 120, 96, 72, 60, 48};
    always #2.5 clk_i = ~clk_i;
    sapf_ctrl sapf_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .bus_i(bus),
        .rdata_o(rdata), .afe_o(afe), .cmp_above_i(cmp), .conversion_end_irq_o(irq),
        .conversion_end_flag_o(flag), .reference_ctrl_enable_o(refen));
    sapf_afe_model sapf_afe_model_i (.clk_i(clk_i), .vin_i(vin), .afe_i(afe), .cmp_above_o(cmp));
    task report_and_stop;
        if (mismatches == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk_i);
        bus.wr <= 1'b0;
    endtask
    task rd(input logic [15:0] a);
        @(posedge clk_i);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk_i);
        bus.rd <= 1'b0;
        #1;
        rv = rdata;
    endtask
    task wait_irq(output int n);
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (irq !== 1'b1 && n < 400);
    endtask
    task count_irq(input int n, output int k);
        k = 0;
        repeat (n) begin
            @(posedge clk_i);
            #1;
            if (irq === 1'b1) k++;
        end
    endtask
    initial begin
        #100000;
        mismatches++;
        report_and_stop();
    end
    initial begin
        v = $urandom(82027);
        for (int i = 0; i < 8; i++) vin[i*8 +: 8] = 8'($urandom % 255);
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(SAPF_OFS_THR);
        check("thr reset", 16'(rv), 16'h0000);
        rd(SAPF_OFS_RESULT);
        check("result reset", 16'(rv), 16'h0000);
        rd(SAPF_OFS_PFM);
        check("pfm reset", 16'(rv), 16'h0000);
        v = $urandom % 256;
        wr(SAPF_OFS_THR, 8'(v));
        rd(SAPF_OFS_THR);
        check("thr rw", 16'(rv), 16'(v));
        for (int i = 0; i < 7; i++) begin
            wr(SAPF_OFS_CHAN, 8'(i + 1));
            wr(SAPF_OFS_MODE, {2'b10, 3'(tcode[i]), 3'b000});
            wait_irq(t);
            wait_irq(t);
            check("period", 16'(t), 16'((tconv[i] / 9) * 9));
            rd(SAPF_OFS_RESULT);
            check("result", 16'(rv), 16'(vin[(i + 1)*8 +: 8]));
        end
        rd(SAPF_OFS_FLAG);
        check("flag sticky", 16'(rv[0]), 16'h0001);
        wr(SAPF_OFS_CHAN, 8'h00);
        wr(SAPF_OFS_FLAG, 8'h00);
        #1;
        check("flag cleared", 16'(flag), 16'h0000);
        wait_irq(t);
        repeat (10) @(posedge clk_i);
        wr(SAPF_OFS_CHAN, 8'h07);
        rd(SAPF_OFS_FLAG);
        check("flag kept", 16'(rv[0]), 16'h0001);
        wait_irq(t);
        rd(SAPF_OFS_RESULT);
        check("new channel", 16'(rv), 16'(vin[63:56]));
        // Seven frozen edges stretch the next conversion by seven cycles.
        wait_irq(t);
        @(posedge clk_i);
        ce <= 1'b0;
        repeat (7) @(posedge clk_i);
        ce <= 1'b1;
        wait_irq(t);
        check("ce freeze", 16'(t), 16'((48 / 9) * 9 + 7 - 8));
        repeat (20) @(posedge clk_i);
        wr(SAPF_OFS_MODE, 8'h30);
        count_irq(100, c);
        check("halt", 16'(c), 16'h0000);
        for (int d = 0; d < 2; d++) begin
            for (int k = 0; k < 2; k++) begin
                wr(SAPF_OFS_MODE, 8'h30);
                wr(SAPF_OFS_FLAG, 8'h00);
                e = vin[31:24] + k;
                wr(SAPF_OFS_THR, 8'(e));
                wr(SAPF_OFS_PFM, {1'b1, 1'(d), 6'b000000});
                wr(SAPF_OFS_CHAN, 8'h03);
                wr(SAPF_OFS_MODE, 8'hb0);
                count_irq(155, c);
                v = ((vin[31:24] >= e) ^ d) ? 2 : 0;
                check("pf irqs", 16'(c), 16'(v));
                check("pf flag", 16'(flag), 16'(v != 0));
            end
        end
        wr(SAPF_OFS_EMU, 8'h01);
        rd(SAPF_OFS_EMU);
        check("emu write", 16'(refen), 16'h0001);
        check("emu read", 16'(rv), 16'h0000);
        // A second reset in mid-run must clear result, flag and the emulation bit.
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(SAPF_OFS_RESULT);
        check("result after reset", 16'(rv), 16'h0000);
        check("flag after reset", 16'(flag), 16'h0000);
        check("emu after reset", 16'(refen), 16'h0000);
        report_and_stop();
    end
endmodule
`default_nettype wire
